// >>> core/otsq_top.sv
// output turn-off sequencer: paged delay and fall settings, status byte and word
`timescale 1ns/1ps
`include "otsq_regs.svh"

module otsq_top #(
  parameter logic [31:0] CYC_PER_MS   = 32'(`OTSQ_CYC_PER_MS),
  parameter logic [31:0] DELAY_MAX    = 32'(`OTSQ_DELAY_MS * `OTSQ_CYC_PER_MS),
  parameter logic [31:0] FALL_MAX     = 32'(`OTSQ_FALL_MS * `OTSQ_CYC_PER_MS),
  parameter logic [31:0] RAMP_MIN_CYC = 32'(`OTSQ_RAMP_MIN_CYC)
) (
  input  wire logic                                mclk_i,
  input  wire logic                                rst_n_i,
  input  wire otsq_pkg::otsq_cmd_type              cmd_i,
  output otsq_pkg::otsq_rsp_type                   rsp_o,
  input  wire logic [`OTSQ_PAGES-1:0]              out_en_i,
  input  wire otsq_pkg::otsq_phase_type            phase_cfg_i,
  input  wire logic [`OTSQ_PAGES-1:0][7:0]         fault_flags_i,
  input  wire logic [`OTSQ_PAGES-1:0][7:0]         status_hi_i,
  output logic      [`OTSQ_PAGES-1:0]              stage_off_o,
  output logic      [`OTSQ_PAGES-1:0]              ramp_active_o,
  output logic      [`OTSQ_PAGES-1:0][31:0]        ramp_len_o
);

  // true when the stack runs four or more phases
  function automatic logic multi_phase(input otsq_pkg::otsq_phase_type ph);
    multi_phase = (ph == otsq_pkg::OTSQ_PH4) || (ph == otsq_pkg::OTSQ_PH6) || (ph == otsq_pkg::OTSQ_PH8);
  endfunction

  // true when the command addresses the given register on the given page
  function automatic logic hit(input otsq_pkg::otsq_cmd_type c, input logic [7:0] code, input logic pg);
    hit = c.valid && (c.code == code) && (c.page == pg);
  endfunction

  logic [`OTSQ_PAGES-1:0][15:0] delay_q;
  logic [`OTSQ_PAGES-1:0][15:0] fall_q;
  logic [`OTSQ_PAGES-1:0][7:0]  sbyte_q;
  logic [`OTSQ_PAGES-1:0][7:0]  shi_q;
  logic [`OTSQ_PAGES-1:0][31:0] delay_cyc;
  logic [`OTSQ_PAGES-1:0][31:0] fall_cyc;
  otsq_pkg::otsq_state_type     state_q [`OTSQ_PAGES];
  logic [`OTSQ_PAGES-1:0][31:0] cnt_q;
  logic [`OTSQ_PAGES-1:0][31:0] len_q;
  otsq_pkg::otsq_rsp_type       rsp_q;
  otsq_pkg::otsq_rsp_type       rsp_d;

  genvar p;
  generate
    for (p = 0; p < `OTSQ_PAGES; p++) begin : g_page
      logic [15:0]              delay_d;
      logic [15:0]              fall_d;
      logic [7:0]               sbyte_d;
      logic [7:0]               shi_d;
      otsq_pkg::otsq_state_type state_d;
      logic [31:0]              cnt_d;
      logic [31:0]              len_d;

      // per-page conversion of the two time words to cycle counts
      otsq_lin2cyc #(
        .CYC_PER_MS (CYC_PER_MS),
        .MAX_CYC    (DELAY_MAX)
      ) u_delay (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .lin_i      (delay_q[p]),
        .cyc_o      (delay_cyc[p])
      );

      otsq_lin2cyc #(
        .CYC_PER_MS (CYC_PER_MS),
        .MAX_CYC    (FALL_MAX)
      ) u_fall (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .lin_i      (fall_q[p]),
        .cyc_o      (fall_cyc[p])
      );

      // paged settings and status storage
      always_comb begin
        delay_d = delay_q[p];
        fall_d  = fall_q[p];
        if (cmd_i.write && hit(cmd_i, `OTSQ_CMD_DELAY, 1'(p))) begin
          delay_d = cmd_i.wdata;
        end
        if (cmd_i.write && hit(cmd_i, `OTSQ_CMD_FALL, 1'(p))) begin
          fall_d = cmd_i.wdata;
        end
        sbyte_d                = fault_flags_i[p];
        sbyte_d[`OTSQ_OFF_BIT] = (state_q[p] != otsq_pkg::OTSQ_ON);
        shi_d                  = status_hi_i[p];
      end

      // turn-off sequence: delay, then ramp or immediate stage-off
      always_comb begin
        state_d = state_q[p];
        cnt_d   = cnt_q[p];
        len_d   = len_q[p];
        case (state_q[p])
          otsq_pkg::OTSQ_ON: begin
            if (!out_en_i[p]) begin
              state_d = otsq_pkg::OTSQ_DELAY;
              cnt_d   = delay_cyc[p];
            end
          end
          otsq_pkg::OTSQ_DELAY: begin
            if (out_en_i[p]) begin
              state_d = otsq_pkg::OTSQ_ON;
            end else if (cnt_q[p] != 32'h0) begin
              cnt_d = cnt_q[p] - 32'h1;
            end else if (multi_phase(phase_cfg_i) || (fall_cyc[p] < RAMP_MIN_CYC)) begin
              state_d = otsq_pkg::OTSQ_OFF;
            end else begin
              state_d = otsq_pkg::OTSQ_RAMP;
              cnt_d   = fall_cyc[p];
              len_d   = fall_cyc[p];
            end
          end
          otsq_pkg::OTSQ_RAMP: begin
            if (out_en_i[p]) begin
              state_d = otsq_pkg::OTSQ_ON;
            end else if (cnt_q[p] != 32'h0) begin
              cnt_d = cnt_q[p] - 32'h1;
            end else begin
              state_d = otsq_pkg::OTSQ_OFF;
            end
          end
          otsq_pkg::OTSQ_OFF: begin
            if (out_en_i[p]) begin
              state_d = otsq_pkg::OTSQ_ON;
            end
          end
          default: begin
            state_d = otsq_pkg::OTSQ_OFF;
          end
        endcase
      end

      // register the page state
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          delay_q[p] <= `OTSQ_RST_TIME;
          fall_q[p]  <= `OTSQ_RST_TIME;
          sbyte_q[p] <= `OTSQ_RST_STATUS;
          shi_q[p]   <= 8'h00;
          state_q[p] <= otsq_pkg::OTSQ_OFF;
          cnt_q[p]   <= 32'h0;
          len_q[p]   <= 32'h0;
        end else begin
          delay_q[p] <= delay_d;
          fall_q[p]  <= fall_d;
          sbyte_q[p] <= sbyte_d;
          shi_q[p]   <= shi_d;
          state_q[p] <= state_d;
          cnt_q[p]   <= cnt_d;
          len_q[p]   <= len_d;
        end
      end

      // outputs toward the power stage
      assign stage_off_o[p]   = (state_q[p] == otsq_pkg::OTSQ_OFF);
      assign ramp_active_o[p] = (state_q[p] == otsq_pkg::OTSQ_RAMP);
      assign ramp_len_o[p]    = len_q[p];

      // disable starts the off-delay
      delay_entry_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q[p] == otsq_pkg::OTSQ_ON) && !out_en_i[p] |=> (state_q[p] == otsq_pkg::OTSQ_DELAY)
          && (cnt_q[p] == $past(delay_cyc[p])))
        else $error("off-delay not started on disable");

      // delay counts down one per cycle while disabled
      delay_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q[p] == otsq_pkg::OTSQ_DELAY) && !out_en_i[p] && (cnt_q[p] != 32'h0)
          |=> (state_q[p] == otsq_pkg::OTSQ_DELAY) && (cnt_q[p] == $past(cnt_q[p]) - 32'h1))
        else $error("off-delay count did not step");

      // stacked phases shut off at once
      stack_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q[p] == otsq_pkg::OTSQ_DELAY) && !out_en_i[p] && (cnt_q[p] == 32'h0)
          && multi_phase(phase_cfg_i) |=> stage_off_o[p] && !ramp_active_o[p])
        else $error("multi-phase stack did not shut off at once");

      // short fall time shuts off at once
      short_fall_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q[p] == otsq_pkg::OTSQ_DELAY) && !out_en_i[p] && (cnt_q[p] == 32'h0)
          && (fall_cyc[p] < RAMP_MIN_CYC) |=> stage_off_o[p])
        else $error("short fall time did not shut off at once");

      // one or two phases with a long fall time ramp for that long
      ramp_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q[p] == otsq_pkg::OTSQ_DELAY) && !out_en_i[p] && (cnt_q[p] == 32'h0)
          && !multi_phase(phase_cfg_i) && (fall_cyc[p] >= RAMP_MIN_CYC)
          |=> ramp_active_o[p] && (ramp_len_o[p] == $past(fall_cyc[p])))
        else $error("fall ramp not started");

      // off bit follows the sequencer one cycle later
      off_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> sbyte_q[p][`OTSQ_OFF_BIT] == $past(state_q[p] != otsq_pkg::OTSQ_ON))
        else $error("status off bit wrong");

      // write to the delay word lands on its own page only
      page_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_i.write && hit(cmd_i, `OTSQ_CMD_DELAY, 1'(p)) |=> delay_q[p] == $past(cmd_i.wdata))
        else $error("paged delay write lost");

      // defaults after reset
      reset_value_a: assert property (@(posedge mclk_i)
        !rst_n_i |=> (delay_q[p] == `OTSQ_RST_TIME) && (fall_q[p] == `OTSQ_RST_TIME) && (sbyte_q[p] == 8'h00))
        else $error("reset defaults wrong");

      // fall ramp counts down one per cycle while disabled
      ramp_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q[p] == otsq_pkg::OTSQ_RAMP) && !out_en_i[p] && (cnt_q[p] != 32'h0)
          |=> ramp_active_o[p] && (cnt_q[p] == $past(cnt_q[p]) - 32'h1))
        else $error("fall ramp count did not step");

      // end of the fall ramp switches the stage off
      ramp_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q[p] == otsq_pkg::OTSQ_RAMP) && !out_en_i[p] && (cnt_q[p] == 32'h0) |=> stage_off_o[p])
        else $error("stage not off after fall ramp");

      // enable brings the page back on from any off-going state
      reenable_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $past(rst_n_i) && (state_q[p] != otsq_pkg::OTSQ_ON) && out_en_i[p] |=> (state_q[p] == otsq_pkg::OTSQ_ON))
        else $error("page not back on after enable");

      // write to the fall word lands on its own page only
      fall_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_i.write && hit(cmd_i, `OTSQ_CMD_FALL, 1'(p)) |=> fall_q[p] == $past(cmd_i.wdata))
        else $error("paged fall write lost");

      // a delay write to the other page leaves this page alone
      other_page_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cmd_i.valid && cmd_i.write && (cmd_i.code == `OTSQ_CMD_DELAY) && (cmd_i.page != 1'(p))
          |=> $stable(delay_q[p]))
        else $error("delay write leaked to the other page");
    end
  endgenerate

  // command decode and read answer
  always_comb begin
    rsp_d = '0;
    if (cmd_i.valid) begin
      rsp_d.ack = 1'b1;
      case (cmd_i.code)
        `OTSQ_CMD_DELAY: rsp_d.rdata = delay_q[cmd_i.page];
        `OTSQ_CMD_FALL:  rsp_d.rdata = fall_q[cmd_i.page];
        `OTSQ_CMD_SBYTE: begin
          rsp_d.rdata = {8'h00, sbyte_q[cmd_i.page]};
          rsp_d.err   = cmd_i.write;
        end
        `OTSQ_CMD_SWORD: begin
          rsp_d.rdata = {shi_q[cmd_i.page], sbyte_q[cmd_i.page]};
          rsp_d.err   = cmd_i.write;
        end
        default: begin
          rsp_d.err = 1'b1;
        end
      endcase
    end
  end

  // answer register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_o = rsp_q;

  // word low byte equals the byte register
  word_alias_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_i.valid && !cmd_i.write && (cmd_i.code == `OTSQ_CMD_SWORD)
      |=> rsp_o.ack && (rsp_o.rdata[7:0] == $past(sbyte_q[cmd_i.page])))
    else $error("status word low byte differs from status byte");

  // writes to the read-only status commands are refused
  status_ro_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_i.valid && cmd_i.write && ((cmd_i.code == `OTSQ_CMD_SBYTE) || (cmd_i.code == `OTSQ_CMD_SWORD))
      |=> rsp_o.ack && rsp_o.err)
    else $error("write to read-only status accepted");

  // byte read returns the status byte with a zero high byte
  byte_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_i.valid && !cmd_i.write && (cmd_i.code == `OTSQ_CMD_SBYTE)
      |=> rsp_o.ack && !rsp_o.err && (rsp_o.rdata == {8'h00, $past(sbyte_q[cmd_i.page])}))
    else $error("status byte read answer wrong");

endmodule

// >>> core/otsq_regs.svh
// offsets, field positions, reset values and timing counts of the turn-off sequencer
`ifndef OTSQ_REGS_SVH
`define OTSQ_REGS_SVH

`define OTSQ_PAGES       2
`define OTSQ_CMD_DELAY   8'h64
`define OTSQ_CMD_FALL    8'h65
`define OTSQ_CMD_SBYTE   8'h78
`define OTSQ_CMD_SWORD   8'h79
`define OTSQ_RST_TIME    16'hCA80
`define OTSQ_RST_STATUS  8'h00
`define OTSQ_OFF_BIT     6
`define OTSQ_EXP_MSB     15
`define OTSQ_EXP_LSB     11
`define OTSQ_MAN_MSB     10
`define OTSQ_CLK_NS      4
`define OTSQ_NS_PER_MS   1000000
`define OTSQ_NS_PER_US   1000
`define OTSQ_CYC_PER_MS  (`OTSQ_NS_PER_MS / `OTSQ_CLK_NS)
`define OTSQ_DELAY_MS    5000
`define OTSQ_FALL_MS     100
`define OTSQ_RAMP_MIN_US 500
`define OTSQ_RAMP_MIN_CYC ((`OTSQ_RAMP_MIN_US * `OTSQ_NS_PER_US + `OTSQ_CLK_NS - 1) / `OTSQ_CLK_NS)

`endif

// >>> core/otsq_pkg.sv
// types shared by the turn-off sequencer files
package otsq_pkg;

  typedef enum logic [2:0] {
    OTSQ_PH1 = 3'h0,
    OTSQ_PH2 = 3'h1,
    OTSQ_PH4 = 3'h2,
    OTSQ_PH6 = 3'h3,
    OTSQ_PH8 = 3'h4
  } otsq_phase_type;

  typedef enum logic [1:0] {
    OTSQ_ON    = 2'h0,
    OTSQ_DELAY = 2'h1,
    OTSQ_RAMP  = 2'h2,
    OTSQ_OFF   = 2'h3
  } otsq_state_type;

  // one management command from the bus front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic        page;
    logic [15:0] wdata;
  } otsq_cmd_type;

  // answer to a command, one cycle after it
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } otsq_rsp_type;

endpackage

// >>> core/otsq_lin2cyc.sv
// linear-11 millisecond word to clock-cycle count, saturated
`timescale 1ns/1ps
`include "otsq_regs.svh"

module otsq_lin2cyc #(
  parameter logic [31:0] CYC_PER_MS = 32'(`OTSQ_CYC_PER_MS),
  parameter logic [31:0] MAX_CYC    = 32'(`OTSQ_DELAY_MS * `OTSQ_CYC_PER_MS)
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] lin_i,
  output logic      [31:0] cyc_o
);

  logic [31:0] cyc_q;
  logic [31:0] cyc_d;
  logic [47:0] prod;
  logic [47:0] scaled;
  logic [4:0]  exp_raw;
  logic [4:0]  shr;

  // time = mantissa * 2^exponent ms; negative mantissa reads as zero
  always_comb begin
    exp_raw = lin_i[`OTSQ_EXP_MSB:`OTSQ_EXP_LSB];
    shr     = 5'(~exp_raw + 5'h01);
    prod    = lin_i[`OTSQ_MAN_MSB] ? 48'h0 : 48'(lin_i[`OTSQ_MAN_MSB-1:0]) * 48'(CYC_PER_MS);
    if (exp_raw[4]) begin
      scaled = prod >> shr;
    end else begin
      scaled = prod << exp_raw;
    end
    cyc_d = (scaled > 48'(MAX_CYC)) ? MAX_CYC : scaled[31:0];
  end

  // registered count
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cyc_q <= 32'h0;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  assign cyc_o = cyc_q;

endmodule

// >>> verification/otsq_host.sv
// management-bus host model that issues commands and collects the answers
`timescale 1ns/1ps

module otsq_host (
  input  wire logic                   mclk_i,
  output otsq_pkg::otsq_cmd_type      cmd_o,
  input  wire otsq_pkg::otsq_rsp_type rsp_i
);
  initial cmd_o = '0;

  // one command per call: valid stands for exactly one taking edge, answer within three cycles
  task automatic xfer(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] wd,
                      output otsq_pkg::otsq_rsp_type rsp);
    int n;
    @(posedge mclk_i);
    cmd_o <= '{valid: 1'b1, write: wr, code: code, page: pg, wdata: wd};
    @(posedge mclk_i);
    cmd_o <= '0;
    rsp = '0;
    for (n = 0; n < 3 && rsp.ack !== 1'b1; n++) begin
      #1 rsp = rsp_i;
      if (rsp.ack !== 1'b1) @(posedge mclk_i);
    end
  endtask

  // read the summary byte and fetch the detail word only when it points there
  task automatic probe(input logic pg, output logic [15:0] st);
    otsq_pkg::otsq_rsp_type r;
    xfer(1'b0, 8'h78, pg, 16'h0000, r);
    st = r.rdata;
    if (r.rdata[0] === 1'b1) begin
      xfer(1'b0, 8'h79, pg, 16'h0000, r);
      st = r.rdata;
    end
  endtask
endmodule

// >>> verification/tb_otsq_top.sv
// self-checking bench of the turn-off sequencer
`timescale 1ns/1ps

module tb_otsq_top;
  typedef struct {
    logic                     pg;
    logic [15:0]              dly;
    logic [15:0]              fall;
    otsq_pkg::otsq_phase_type ph;
    int                       d;
    int                       f;
  } otsq_row_type;

  // page, delay word, fall word, phases, delay cycles, fall cycles (-1 means switch off at once)
  otsq_row_type rows [9] = '{
    '{1'b0, 16'h0002, 16'h0001, otsq_pkg::OTSQ_PH1, 8, 4},
    '{1'b1, 16'h0001, 16'h0002, otsq_pkg::OTSQ_PH2, 4, 8},
    '{1'b0, 16'h0000, 16'hF001, otsq_pkg::OTSQ_PH1, 0, -1},
    '{1'b1, 16'h0001, 16'h0002, otsq_pkg::OTSQ_PH4, 4, -1},
    '{1'b0, 16'h0001, 16'h0002, otsq_pkg::OTSQ_PH6, 4, -1},
    '{1'b1, 16'h0001, 16'h0002, otsq_pkg::OTSQ_PH8, 4, -1},
    '{1'b0, 16'h0001, 16'h0065, otsq_pkg::OTSQ_PH2, 4, 400},
    '{1'b1, 16'h0001, 16'h07FF, otsq_pkg::OTSQ_PH2, 4, -1},
    '{1'b0, 16'h1A72, 16'h0001, otsq_pkg::OTSQ_PH4, 20000, -1}
  };

  logic                     mclk;
  logic                     rst_n;
  logic [1:0]               out_en;
  otsq_pkg::otsq_phase_type ph;
  logic [1:0][7:0]          flags;
  logic [1:0][7:0]          hi;
  logic [1:0]               stage_off;
  logic [1:0]               ramp_act;
  logic [1:0][31:0]         ramp_len;
  logic [15:0]              st;
  otsq_pkg::otsq_cmd_type   cmd;
  otsq_pkg::otsq_rsp_type   rsp;
  otsq_pkg::otsq_rsp_type   r;
  int                       err_total = 0;
  int                       n_compared = 0;

  // clock of 4 ns
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  otsq_top #(.CYC_PER_MS(32'h4), .DELAY_MAX(32'h4E20), .FALL_MAX(32'h190), .RAMP_MIN_CYC(32'h2)) u_otsq_top (
    .mclk_i        (mclk),
    .rst_n_i       (rst_n),
    .cmd_i         (cmd),
    .rsp_o         (rsp),
    .out_en_i      (out_en),
    .phase_cfg_i   (ph),
    .fault_flags_i (flags),
    .status_hi_i   (hi),
    .stage_off_o   (stage_off),
    .ramp_active_o (ramp_act),
    .ramp_len_o    (ramp_len)
  );

  otsq_host u_otsq_host (
    .mclk_i (mclk),
    .cmd_o  (cmd),
    .rsp_i  (rsp)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // disable one page, time the ramp and the switch-off, then enable it again
  task automatic run_off(input logic pg, input otsq_pkg::otsq_phase_type p, input int d, input int f);
    int n;
    int nr;
    n = 0;
    nr = -1;
    @(posedge mclk);
    ph <= p;
    out_en[pg] <= 1'b0;
    while (n < 30000 && stage_off[pg] !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (ramp_act[pg] === 1'b1 && nr < 0) nr = n;
    end
    chk(32'(n), 32'(f < 0 ? d + 2 : d + f + 3));
    chk(32'(nr), 32'(f < 0 ? -1 : d + 2));
    if (f >= 0) chk(ramp_len[pg], 32'(f));
    chk(32'(stage_off[~pg]), 32'h0);
    u_otsq_host.probe(pg, st);
    chk(32'(st[6]), 32'h1);
    @(posedge mclk);
    out_en[pg] <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(stage_off[pg]), 32'h0);
  endtask

  // watchdog well past the expected run length
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end

  initial begin
    rst_n = 1'b0;
    out_en = 2'h3;
    ph = otsq_pkg::OTSQ_PH1;
    flags = '0;
    hi = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      u_otsq_host.xfer(1'b1, 8'h64, rows[i].pg, rows[i].dly, r);
      chk(32'({r.ack, r.err}), 32'h2);
      u_otsq_host.xfer(1'b1, 8'h65, rows[i].pg, rows[i].fall, r);
      chk(32'({r.ack, r.err}), 32'h2);
      u_otsq_host.xfer(1'b0, 8'h64, rows[i].pg, 16'h0000, r);
      chk(32'(r.rdata), 32'(rows[i].dly));
      u_otsq_host.xfer(1'b0, 8'h65, rows[i].pg, 16'h0000, r);
      chk(32'(r.rdata), 32'(rows[i].fall));
      run_off(rows[i].pg, rows[i].ph, rows[i].d, rows[i].f);
    end
    // second reset mid-run restores the start values on both pages
    @(posedge mclk);
    rst_n <= 1'b0;
    flags <= {8'h7D, 8'h00};
    hi <= {8'hA5, 8'h00};
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int c = 8'h64; c < 8'h66; c++) begin
        u_otsq_host.xfer(1'b0, 8'(c), 1'(p), 16'h0000, r);
        chk(32'(r.rdata), 32'hCA80);
      end
    end
    u_otsq_host.probe(1'b0, st);
    chk(32'(st), 32'h0);
    u_otsq_host.probe(1'b1, st);
    chk(32'(st), 32'hA53D);
    // refused writes to the read-only byte and word and a refused read of an unmapped code
    u_otsq_host.xfer(1'b1, 8'h78, 1'b0, 16'h00FF, r);
    chk(32'({r.ack, r.err}), 32'h3);
    u_otsq_host.xfer(1'b1, 8'h79, 1'b1, 16'h00FF, r);
    chk(32'({r.ack, r.err}), 32'h3);
    u_otsq_host.xfer(1'b0, 8'h00, 1'b0, 16'h0000, r);
    chk(32'({r.ack, r.err}), 32'h3);
    u_otsq_host.probe(1'b0, st);
    chk(32'(st), 32'h0);
    u_otsq_host.probe(1'b1, st);
    chk(32'(st), 32'hA53D);
    // a write to one page leaves the other page alone
    u_otsq_host.xfer(1'b1, 8'h64, 1'b1, 16'h0003, r);
    chk(32'({r.ack, r.err}), 32'h2);
    u_otsq_host.xfer(1'b0, 8'h64, 1'b0, 16'h0000, r);
    chk(32'(r.rdata), 32'hCA80);
    // start values give 20 delay cycles and a 20 cycle ramp
    run_off(1'b0, otsq_pkg::OTSQ_PH1, 20, 20);
    tally_and_finish;
  end
endmodule
